/* hdl/otsm_pkg.sv */
// Package of constants and types for the overtemp state monitor
package otsm_pkg;

  // ----------------------------------------
  // Temperature representation
  // ----------------------------------------
  // Temperature is a signed whole-degree Celsius value
  localparam int unsigned TEMP_W = 8;

  localparam logic signed [TEMP_W-1:0] WARN_ENTER_C  = 8'sh46;
  localparam logic signed [TEMP_W-1:0] WARN_EXIT_C   = 8'sh41;
  localparam logic signed [TEMP_W-1:0] FAULT_ENTER_C = 8'sh50;
  localparam logic signed [TEMP_W-1:0] FAULT_EXIT_C  = 8'sh4b;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic signed [TEMP_W-1:0] TEMP_RST = 8'sh00;
  localparam logic                     VALID_RST = 1'b0;
  localparam logic                     ALLOW_RST = 1'b1;
  localparam logic                     EVENT_RST = 1'b0;

  // ----------------------------------------
  // Reported status codes
  // ----------------------------------------
  localparam logic [1:0] CODE_NORMAL  = 2'h0;
  localparam logic [1:0] CODE_WARNING = 2'h1;
  localparam logic [1:0] CODE_FAULT   = 2'h2;

  // ----------------------------------------
  // Thermal state encoding
  // ----------------------------------------
  // Gray coded along normal, warning, fault; one bit flips per step
  typedef enum logic [1:0] {
    OTSM_NORMAL  = 2'h0,
    OTSM_WARNING = 2'h1,
    OTSM_FAULT   = 2'h3
  } otsm_state_t;

endpackage : otsm_pkg

/* hdl/otsm_temp_capture.sv */
// Registered capture of the on-board temperature sensor reading
`timescale 1ns/1ps

module otsm_temp_capture (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              sample_valid,
  input  wire logic signed [otsm_pkg::TEMP_W-1:0] sample_temp,
  output logic signed      [otsm_pkg::TEMP_W-1:0] temp_r,
  output logic                                   temp_valid_r
);

  // ----------------------------------------
  // Hold last converted reading
  // ----------------------------------------
  // Reading only updates on a valid sample, so a stalled sensor holds state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_r <= otsm_pkg::TEMP_RST;
    end else if (sample_valid) begin
      temp_r <= sample_temp;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_valid_r <= otsm_pkg::VALID_RST;
    end else begin
      temp_valid_r <= sample_valid;
    end
  end

endmodule : otsm_temp_capture

/* hdl/otsm_monitor.sv */
// Thermal state monitor with hysteresis and acquisition suspend
`timescale 1ns/1ps

// What this block does
// - Readable temperature value taken from the integrated sensor.
// - Readable thermal state, exactly one of normal, warning, fault.
// - Normal reported while below 70 C with no higher state; acquisition allowed.
// - Above 70 C enter warning; acquisition continues.
// - Warning returns to normal only below 65 C.
// - Above 80 C enter fault and suspend acquisition.
// - Fault keeps acquisition suspended until temperature below 75 C.
// - Monitoring enable switches only the change event on and off; state and acquisition permit ignore it.
// - While enabled, pulse a change event on each new state value.
module otsm_monitor (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              sample_valid,
  input  wire logic signed [otsm_pkg::TEMP_W-1:0] sample_temp,
  input  wire logic                              thermal_watch_enable,
  output logic signed      [otsm_pkg::TEMP_W-1:0] temperature_r,
  output logic             [1:0]                 thermal_state_r,
  output logic                                   acquisition_allow_r,
  output logic                                   thermal_state_change_event_r
);

  // ----------------------------------------
  // Sensor capture
  // ----------------------------------------
  // Two stages: capture, then readout and state move on the same edge
  logic signed [otsm_pkg::TEMP_W-1:0] temp_cap;
  logic                               temp_valid;

  otsm_temp_capture u_capture (
    .clk          (clk),
    .rst_b        (rst_b),
    .sample_valid (sample_valid),
    .sample_temp  (sample_temp),
    .temp_r       (temp_cap),
    .temp_valid_r (temp_valid)
  );

  // ----------------------------------------
  // Temperature readout
  // ----------------------------------------
  logic signed [otsm_pkg::TEMP_W-1:0] temperature_nxt;

  always_comb begin
    temperature_nxt = temp_cap;
  end

  // Mirrors the capture register so readout and state stay in step
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      temperature_r <= otsm_pkg::TEMP_RST;
    end else begin
      temperature_r <= temperature_nxt;
    end
  end

  // ----------------------------------------
  // Threshold comparisons
  // ----------------------------------------
  // Strict compares: a reading equal to a threshold keeps the present state
  // Signed compares, so readings below zero count as cool
  logic above_warn_enter;
  logic above_fault_enter;
  logic below_warn_exit;
  logic below_fault_exit;

  always_comb begin
    above_warn_enter  = (temp_cap > otsm_pkg::WARN_ENTER_C);
    above_fault_enter = (temp_cap > otsm_pkg::FAULT_ENTER_C);
    below_warn_exit   = (temp_cap < otsm_pkg::WARN_EXIT_C);
    below_fault_exit  = (temp_cap < otsm_pkg::FAULT_EXIT_C);
  end

  // ----------------------------------------
  // Evaluation strobe
  // ----------------------------------------
  // The state only moves on a fresh reading; a stalled sensor freezes it
  logic eval_en;

  always_comb begin
    eval_en = temp_valid;
  end

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  otsm_pkg::otsm_state_t state_r;
  otsm_pkg::otsm_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      otsm_pkg::OTSM_NORMAL: begin
        if (above_fault_enter) begin
          state_nxt = otsm_pkg::OTSM_FAULT;
        end else if (above_warn_enter) begin
          state_nxt = otsm_pkg::OTSM_WARNING;
        end else begin
          state_nxt = otsm_pkg::OTSM_NORMAL;
        end
      end
      otsm_pkg::OTSM_WARNING: begin
        if (above_fault_enter) begin
          state_nxt = otsm_pkg::OTSM_FAULT;
        end else if (below_warn_exit) begin
          state_nxt = otsm_pkg::OTSM_NORMAL;
        end else begin
          state_nxt = otsm_pkg::OTSM_WARNING;
        end
      end
      otsm_pkg::OTSM_FAULT: begin
        // Step through warning so the lower exit threshold still governs return
        if (below_fault_exit) begin
          state_nxt = otsm_pkg::OTSM_WARNING;
        end else begin
          state_nxt = otsm_pkg::OTSM_FAULT;
        end
      end
      default: begin
        // Unused encoding recovers to normal rather than locking up
        state_nxt = otsm_pkg::OTSM_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= otsm_pkg::OTSM_NORMAL;
    end else if (eval_en) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Status code
  // ----------------------------------------
  // Internal state is Gray coded; the reported field keeps its fixed layout
  // Code 11 is never produced, whatever the internal state holds
  logic [1:0] state_code;

  always_comb begin
    state_code = otsm_pkg::CODE_NORMAL;
    case (state_r)
      otsm_pkg::OTSM_NORMAL: begin
        state_code = otsm_pkg::CODE_NORMAL;
      end
      otsm_pkg::OTSM_WARNING: begin
        state_code = otsm_pkg::CODE_WARNING;
      end
      otsm_pkg::OTSM_FAULT: begin
        state_code = otsm_pkg::CODE_FAULT;
      end
      default: begin
        state_code = otsm_pkg::CODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thermal_state_r <= otsm_pkg::CODE_NORMAL;
    end else begin
      thermal_state_r <= state_code;
    end
  end

  // ----------------------------------------
  // Acquisition permit
  // ----------------------------------------
  // Protection acts regardless of the enable; only the event is gated
  logic acquisition_allow_nxt;

  always_comb begin
    acquisition_allow_nxt = (state_r != otsm_pkg::OTSM_FAULT);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acquisition_allow_r <= otsm_pkg::ALLOW_RST;
    end else begin
      acquisition_allow_r <= acquisition_allow_nxt;
    end
  end

  // ----------------------------------------
  // Change event
  // ----------------------------------------
  // Reset matches the reported state so no false event follows reset
  logic [1:0] seen_state_r;
  logic       state_moved;
  logic       thermal_state_change_event_nxt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_state_r <= otsm_pkg::CODE_NORMAL;
    end else begin
      seen_state_r <= thermal_state_r;
    end
  end

  // A change made while disabled is dropped, not held back for later
  always_comb begin
    state_moved                    = (thermal_state_r != seen_state_r);
    thermal_state_change_event_nxt = 1'b0;
    if (thermal_watch_enable) begin
      thermal_state_change_event_nxt = state_moved;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thermal_state_change_event_r <= otsm_pkg::EVENT_RST;
    end else begin
      thermal_state_change_event_r <= thermal_state_change_event_nxt;
    end
  end

endmodule : otsm_monitor

/* testbench/otsm_monitor_asserts.sv */
// Port checker of the thermal state monitor
`timescale 1ns/1ps
module otsm_asserts (
  input wire logic                               clk,
  input wire logic                               rst_b,
  input wire logic                               sample_valid,
  input wire logic                               thermal_watch_enable,
  input wire logic                               acquisition_allow_r,
  input wire logic                               thermal_state_change_event_r,
  input wire logic signed [otsm_pkg::TEMP_W-1:0] sample_temp,
  input wire logic signed [otsm_pkg::TEMP_W-1:0] temperature_r,
  input wire logic        [1:0]                  thermal_state_r
);
  logic signed [otsm_pkg::TEMP_W-1:0] t_q;
  logic [1:0] s_q;
  // No reset: reset spans a clock, so copies settle
  always_ff @(posedge clk) begin
    t_q <= temperature_r;
    s_q <= thermal_state_r;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_allow_level:
    assert property (acquisition_allow_r == (thermal_state_r != 2'h2)) else $error("allow");
  chk_temp_capture:
    assert property (sample_valid |-> ##2 temperature_r == $past(sample_temp, 2))
    else $error("temp");
  chk_fault_enter:
    assert property (t_q > 8'sh50 |-> thermal_state_r == 2'h2) else $error("fault");
  chk_fault_exit: assert property (
    s_q == 2'h2 |-> thermal_state_r == (t_q < 8'sh4b ? 2'h1 : 2'h2)) else $error("exit");
  chk_warn_enter: assert property (
    s_q == 2'h0 && t_q <= 8'sh50 |-> thermal_state_r == {1'b0, t_q > 8'sh46})
    else $error("warn");
  chk_warn_hold: assert property (
    s_q == 2'h1 && t_q >= 8'sh41 && t_q <= 8'sh50 |-> thermal_state_r == 2'h1)
    else $error("hold");
  chk_state_legal:
    assert property (thermal_state_r != 2'h3) else $error("code");
  // Event register reads the enable at the same edge the change is seen
  chk_event_fire: assert property (
    $changed(thermal_state_r) && thermal_watch_enable |=> thermal_state_change_event_r)
    else $error("event");
  chk_event_cause: assert property (
    thermal_state_change_event_r |-> $past(thermal_watch_enable)
    && s_q != $past(thermal_state_r, 2)) else $error("cause");
endmodule : otsm_asserts
bind otsm_monitor otsm_asserts u_chk (
  .clk                          (clk),
  .rst_b                        (rst_b),
  .sample_valid                 (sample_valid),
  .thermal_watch_enable         (thermal_watch_enable),
  .acquisition_allow_r          (acquisition_allow_r),
  .thermal_state_change_event_r (thermal_state_change_event_r),
  .sample_temp                  (sample_temp),
  .temperature_r                (temperature_r),
  .thermal_state_r              (thermal_state_r)
);

/* testbench/tb_otsm_monitor.sv */
// Self-checking bench of the thermal state monitor
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_otsm_monitor;
  logic clk = 1'b0, rst_b = 1'b0, vld = 1'b0, en = 1'b1, al, ev;
  logic signed [7:0] tin = 8'sh00, tr;
  logic [1:0] st;
  int n_mismatch = 0, num_checks = 0, n_evt = 0;
  otsm_monitor dut (.clk(clk), .rst_b(rst_b), .sample_valid(vld), .sample_temp(tin),
    .thermal_watch_enable(en), .temperature_r(tr), .thermal_state_r(st),
    .acquisition_allow_r(al), .thermal_state_change_event_r(ev));
  initial begin
    forever #2 clk = ~clk;
  end
  // Pulses are counted so checks need not hit the exact cycle; read mid-cycle
  always @(negedge clk) if (ev === 1'b1) n_evt++;
  task automatic put(input logic signed [7:0] v, input logic [1:0] s);
    @(posedge clk);
    #1 vld = 1'b1;
    tin = v;
    @(posedge clk);
    #1 vld = 1'b0;
    repeat (5) @(posedge clk);
    #1 `CHK("temp", v, tr)
    `CHK("state", s, st)
    `CHK("allow", s != 2'h2, al)
  endtask : put
  task automatic t_cycle;
    put(8'sh46, 2'h0);
    put(8'sh47, 2'h1);
    put(8'sh41, 2'h1);
    put(8'sh40, 2'h0);
    put(8'sh51, 2'h2);
    put(8'sh4b, 2'h2);
    put(8'sh3c, 2'h1);
    put(8'sh3c, 2'h0);
    `CHK("events", 5, n_evt)
    $display("cycle test done");
  endtask : t_cycle
  task automatic t_quiet;
    en = 1'b0;
    put(8'sh48, 2'h1);
    put(8'shfb, 2'h0);
    `CHK("events", 5, n_evt)
    $display("quiet test done");
  endtask : t_quiet
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial begin
    #2000 n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    t_cycle();
    t_quiet();
    end_sim();
  end
endmodule : tb_otsm_monitor
